/* design/rfrl_pkg.sv */
package rfrl_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned NUM_REGS   = 8;
  localparam int unsigned ADDR_W     = 3;
  localparam int unsigned ENC_W      = 2;
  // encoding class of an access
  localparam logic [1:0]  ENC_NORMAL = 2'h0;
  localparam logic [1:0]  ENC_RSV32  = 2'h1;
  localparam logic [1:0]  ENC_RSV64  = 2'h2;
  // field kind per bit
  localparam logic [2:0]  KIND_FUNC   = 3'h0;
  localparam logic [2:0]  KIND_RZ     = 3'h1;
  localparam logic [2:0]  KIND_RO     = 3'h2;
  localparam logic [2:0]  KIND_CTXRZ  = 3'h3;
  localparam logic [2:0]  KIND_CTXRO  = 3'h4;
  localparam logic [2:0]  KIND_MIXED  = 3'h5;
  localparam logic [DATA_W-1:0] RST_VALUE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNK_VALUE = 32'h0000_0000;
endpackage

/* design/rfrl_field_bit.sv */
`timescale 1ns/10ps
`default_nettype none
module rfrl_field_bit #(
  parameter logic [2:0] KIND     = rfrl_pkg::KIND_FUNC,
  parameter bit         STORAGE  = 1'b1,
  parameter bit         MIX_STORE = 1'b1,
  parameter logic       RST_BIT  = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic wr_direct,
  input  wire logic wr_indirect,
  input  wire logic wr_bit,
  input  wire logic ctx_rsv,
  output logic      rd_bit
);
  logic store_q;
  logic hard;
  logic fval;
  assign hard = (KIND == rfrl_pkg::KIND_RZ || KIND == rfrl_pkg::KIND_RO)
                && !STORAGE;
  assign fval = (KIND == rfrl_pkg::KIND_RO || KIND == rfrl_pkg::KIND_CTXRO);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      store_q <= RST_BIT;
    end else if (wr_indirect && (KIND == rfrl_pkg::KIND_RZ ||
               KIND == rfrl_pkg::KIND_RO ||
               ((KIND == rfrl_pkg::KIND_CTXRZ ||
                 KIND == rfrl_pkg::KIND_CTXRO) && ctx_rsv))) begin
      store_q <= fval;
    end else if (wr_direct || wr_indirect) begin
      store_q <= wr_bit;
    end
  end

  always_comb begin
    if (hard) begin
      rd_bit = fval;
    end else if (KIND == rfrl_pkg::KIND_MIXED && !MIX_STORE) begin
      rd_bit = 1'b0;
    end else begin
      rd_bit = store_q;
    end
  end
endmodule
`default_nettype wire

/* design/rfrl_encode_check.sv */
`timescale 1ns/10ps
`default_nettype none
module rfrl_encode_check (
  input  wire logic [1:0] enc_class,
  output logic            unpred,
  output logic            undef
);
  assign unpred = (enc_class == rfrl_pkg::ENC_RSV32);
  assign undef  = (enc_class == rfrl_pkg::ENC_RSV64);
endmodule
`default_nettype wire

/* design/rfrl_bank.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - hardwired zero reserved bits read 0, writes dropped
// - stored zero reserved bits cleared by indirect write
// - writable reserved bits read last value written, reset value first
// - direct write updates the bit's own storage element
// - reserved bit values drive nothing except read data
// - constant or storage chosen per bit by parameter
// - context reserved bits always stored, indirect write with ctx_rsv set forces 0 or 1
// - hardwired one reserved bits read 1, writes dropped
// - stored one reserved bits set by indirect write
// - mixed zero/one bits either ignore writes or store them
// - read-only reserved bits read 0 or 1 by kind
// - reserved 32-bit encodings unpredictable, 64-bit raise exception
// - unknown read data never leaks privileged information
module rfrl_bank #(
  parameter logic [2:0] KIND [32]  = '{default: rfrl_pkg::KIND_FUNC},
  parameter logic [31:0] STORAGE   = 32'hffff_ffff,
  parameter logic [31:0] MIX_STORE = 32'hffff_ffff
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        acc_indirect,
  input  wire logic [1:0]  acc_enc,
  input  wire logic [2:0]  acc_addr,
  input  wire logic [31:0] acc_wdata,
  input  wire logic        ctx_rsv,
  output logic [31:0]      rdata_q,
  output logic             rvalid_q,
  output logic             undef_q,
  output logic             unpred_q,
  output logic [31:0]      func_q
);
  logic [31:0] rd_bits [8];
  logic [7:0]  sel;
  logic        unpred;
  logic        undef;
  logic        ok;

  rfrl_encode_check u_enc (
    .enc_class (acc_enc),
    .unpred    (unpred),
    .undef     (undef)
  );

  assign ok = acc_valid && !undef && !unpred;

  genvar r;
  genvar b;
  generate
    for (r = 0; r < 8; r++) begin : g_reg
      assign sel[r] = ok && acc_write && (acc_addr == 3'(r));
      for (b = 0; b < 32; b++) begin : g_bit
        rfrl_field_bit #(
          .KIND      (KIND[b]),
          .STORAGE   (STORAGE[b]),
          .MIX_STORE (MIX_STORE[b]),
          .RST_BIT   (rfrl_pkg::RST_VALUE[b])
        ) u_bit (
          .sys_clk     (sys_clk),
          .sys_rst     (sys_rst),
          .wr_direct   (sel[r] && !acc_indirect),
          .wr_indirect (sel[r] && acc_indirect),
          .wr_bit      (acc_wdata[b]),
          .ctx_rsv     (ctx_rsv),
          .rd_bit      (rd_bits[r][b])
        );
      end
    end
  endgenerate

  function automatic logic [31:0] func_mask();
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 32; i++) begin
      m[i] = (KIND[i] == rfrl_pkg::KIND_FUNC);
    end
    return m;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= acc_valid && !acc_write && !undef;
      if (acc_valid && !acc_write) begin
        rdata_q <= (unpred || undef) ? rfrl_pkg::UNK_VALUE :
                   rd_bits[acc_addr];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      undef_q  <= 1'b0;
      unpred_q <= 1'b0;
    end else begin
      undef_q  <= acc_valid && undef;
      unpred_q <= acc_valid && unpred;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      func_q <= 32'h0000_0000;
    end else begin
      func_q <= rd_bits[0] & func_mask();
    end
  end
endmodule
`default_nettype wire

/* tb/rfrl_bank_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module rfrl_bank_chk (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [1:0]  acc_enc,
  input wire logic [31:0] rdata_q,
  input wire logic        rvalid_q,
  input wire logic        undef_q,
  input wire logic        unpred_q,
  input wire logic [31:0] func_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd;
    acc_valid && !acc_write && acc_enc == 2'h0;
  endsequence
  sequence s_r64;
    acc_valid && acc_enc == 2'h2;
  endsequence
  a_read_answer: assert property (s_rd |=> rvalid_q && !unpred_q)
    else $error("read not answered");
  a_enc64_undef: assert property (s_r64 |=> undef_q && !rvalid_q)
    else $error("no exception");
  a_enc32_unpred: assert property (
    acc_valid && acc_enc == 2'h1 |=> unpred_q && !undef_q)
    else $error("no unpred pulse");
  a_no_pulse: assert property (
    !acc_valid |=> !(rvalid_q || undef_q || unpred_q))
    else $error("spurious pulse");
  a_zero_const: assert property (rvalid_q |-> !rdata_q[8])
    else $error("const zero bit set");
  a_one_const: assert property (
    rvalid_q && !unpred_q |-> rdata_q[10])
    else $error("const one bit clear");
  a_mixed_drop: assert property (rvalid_q |-> !rdata_q[14])
    else $error("mixed bit stored");
  a_unk_zero: assert property (
    rvalid_q && unpred_q |-> rdata_q == 32'h0)
    else $error("unknown data nonzero");
  a_func_mask: assert property ((func_q & 32'h0000_cf00) == 32'h0)
    else $error("reserved bit reaches func");
endmodule
bind rfrl_bank rfrl_bank_chk rfrl_bank_chk_i (.sys_clk, .sys_rst,
  .acc_valid, .acc_write, .acc_enc, .rdata_q, .rvalid_q, .undef_q,
  .unpred_q, .func_q);
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_top;
  logic sys_clk, sys_rst, acc_valid, acc_write, acc_indirect, ctx_rsv;
  logic [1:0]  acc_enc;
  logic [2:0]  acc_addr;
  logic [31:0] acc_wdata, rdata_q, func_q;
  logic        rvalid_q, undef_q, unpred_q;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  rfrl_bank #(.KIND('{8: rfrl_pkg::KIND_RZ, 9: rfrl_pkg::KIND_RZ,
    10: rfrl_pkg::KIND_RO, 11: rfrl_pkg::KIND_RO, 12: rfrl_pkg::KIND_CTXRZ,
    13: rfrl_pkg::KIND_CTXRO, 14: rfrl_pkg::KIND_MIXED,
    15: rfrl_pkg::KIND_MIXED, default: rfrl_pkg::KIND_FUNC}),
    .STORAGE(32'hffff_faff), .MIX_STORE(32'hffff_bfff)) rfrl_bank_i (
    .sys_clk, .sys_rst, .acc_valid, .acc_write, .acc_indirect, .acc_enc,
    .acc_addr, .acc_wdata, .ctx_rsv, .rdata_q, .rvalid_q, .undef_q,
    .unpred_q, .func_q);
  function automatic logic [31:0] nxt(input logic [31:0] d, input logic i, c);
    nxt = d & 32'hffff_baff | 32'h0000_0400;
    if (i) nxt = nxt & 32'hffff_fdff | 32'h0000_0800;
    if (i && c) nxt = nxt & 32'hffff_efff | 32'h0000_2000;
  endfunction
  task automatic acc(input logic w, i, input logic [1:0] e,
                     input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1 {acc_valid, acc_write, acc_indirect, acc_enc, acc_addr, acc_wdata} =
      {1'b1, w, i, e, a, d};
    @(posedge sys_clk);
    #1 acc_valid = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] x);
    acc(1'b0, 1'b0, 2'h0, a, 32'h0);
    `CHK("rdata", x, rdata_q)
  endtask
  task automatic t_direct;
    ctx_rsv = 1'b1;
    acc(1'b1, 1'b0, 2'h0, 3'h0, 32'hffff_ffff);
    rd(3'h0, nxt(32'hffff_ffff, 1'b0, 1'b1));
    `CHK("func", 32'hffff_00ff, func_q & 32'hffff_00ff)
    acc(1'b1, 1'b0, 2'h0, 3'h0, 32'h0);
    rd(3'h0, 32'h0000_0400);
    acc(1'b1, 1'b0, 2'h0, 3'h1, 32'h0000_2c00);
    rd(3'h1, nxt(32'h0000_2c00, 1'b0, 1'b1));
  endtask
  task automatic t_indirect;
    acc(1'b1, 1'b1, 2'h0, 3'h0, 32'h1234_92a5);
    ctx_rsv = 1'b0;
    acc(1'b1, 1'b1, 2'h0, 3'h7, 32'h1234_92a5);
    rd(3'h7, nxt(32'h1234_92a5, 1'b1, 1'b0));
    rd(3'h0, nxt(32'h1234_92a5, 1'b1, 1'b1));
  endtask
  task automatic t_rsv;
    acc(1'b1, 1'b0, 2'h1, 3'h7, 32'h0);
    `CHK("unpred", 1'b1, unpred_q)
    acc(1'b1, 1'b0, 2'h2, 3'h7, 32'h0);
    `CHK("undef", 1'b1, undef_q)
    acc(1'b0, 1'b0, 2'h1, 3'h7, 32'h0);
    `CHK("unk_rdata", 32'h0, rdata_q)
    `CHK("rvalid", 1'b1, rvalid_q)
    rd(3'h7, nxt(32'h1234_92a5, 1'b1, 1'b0));
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #5000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {sys_rst, acc_valid, acc_write, acc_indirect, ctx_rsv} = 5'h10;
    {acc_enc, acc_addr, acc_wdata} = '0;
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    rd(3'h0, 32'h0000_0400);
    t_direct();
    t_indirect();
    t_rsv();
    wrap_up();
  end
endmodule
`default_nettype wire
